// ==== common/nsxd_pkg.sv ====
`default_nettype none
package nsxd_pkg;
	localparam int unsigned INSTR_W    = 14;
	localparam int unsigned DATA_W     = 8;
	localparam int unsigned ADDR_W     = 7;
	localparam int unsigned DIR_COUNT  = 3;
	localparam int unsigned DIR_IDX_W  = 2;

	// Major opcode fields
	localparam logic [5:0] OP_SWAP_MAJOR = 6'h0e;
	localparam logic [5:0] OP_XORL_MAJOR = 6'h3a;
	localparam logic [10:0] OP_DIRL_HI   = 11'h00c;
	localparam int unsigned MAJOR_HI     = 13;
	localparam int unsigned MAJOR_LO     = 8;
	localparam int unsigned DEST_BIT     = 7;
	localparam int unsigned DIRL_HI_LO   = 3;

	// Direction register selection, file addresses and reset values
	localparam logic [2:0] DIR_SEL_FIRST = 3'h5;
	localparam logic [2:0] DIR_SEL_LAST  = 3'h7;
	localparam logic [ADDR_W-1:0] DIR_FILE_BASE = 7'h05;
	localparam logic [DATA_W-1:0] DIR_RESET     = 8'hff;
	localparam logic [DATA_W-1:0] ACC_RESET     = 8'h00;
endpackage
`default_nettype wire

// ==== core/nsxd_dir_bank.sv ====
`default_nettype none
module nsxd_dir_bank
	import nsxd_pkg::*;
(
	input  wire logic                   clock,
	input  wire logic                   reset,
	input  wire logic                   wr_en,
	input  wire logic [DIR_IDX_W-1:0]   wr_idx,
	input  wire logic [DATA_W-1:0]      wr_data,
	input  wire logic [DIR_IDX_W-1:0]   rd_idx,
	output logic      [DATA_W-1:0]      rd_data,
	output logic      [DIR_COUNT*DATA_W-1:0] dir_flat
);
	logic [DATA_W-1:0] dir_r [DIR_COUNT];

	generate
		for (genvar i = 0; i < DIR_COUNT; i++) begin : g_dir
			always_ff @(posedge clock) begin
				if (reset) begin
					dir_r[i] <= DIR_RESET;
				end else if (wr_en && wr_idx == DIR_IDX_W'(i)) begin
					dir_r[i] <= wr_data;
				end
			end
			assign dir_flat[i*DATA_W +: DATA_W] = dir_r[i];
		end
	endgenerate

	// Registered read port keeps the file read path flop-driven
	always_ff @(posedge clock) begin
		if (reset) begin
			rd_data <= DIR_RESET;
		end else if (rd_idx < DIR_IDX_W'(DIR_COUNT)) begin
			rd_data <= dir_r[rd_idx];
		end else begin
			rd_data <= '0;
		end
	end
endmodule
`default_nettype wire

// ==== core/nsxd_exec.sv ====
`default_nettype none
module nsxd_exec
	import nsxd_pkg::*;
(
	input  wire logic                        clock,
	input  wire logic                        reset,
	input  wire logic                        instr_valid,
	input  wire logic [INSTR_W-1:0]          instr,
	input  wire logic [DATA_W-1:0]           file_rd_data,
	output logic      [ADDR_W-1:0]           file_addr,
	output logic                             file_wr_en,
	output logic      [DATA_W-1:0]           file_wr_data,
	input  wire logic                        core_file_wr_en,
	input  wire logic [ADDR_W-1:0]           core_file_addr,
	input  wire logic [DATA_W-1:0]           core_file_wr_data,
	output logic      [DATA_W-1:0]           dir_rd_data,
	output logic      [DIR_COUNT*DATA_W-1:0] dir_regs,
	output logic      [DATA_W-1:0]           acc,
	output logic                             result_null_flag,
	output logic                             instr_accepted,
	output logic                             illegal_op
);
	import nsxd_pkg::*;

	logic [DATA_W-1:0] acc_r;
	logic [DATA_W-1:0] acc_nxt;
	logic              null_r;
	logic              is_swap;
	logic              is_xorl;
	logic              is_dirl;
	logic              dir_sel_ok;
	logic              dest_file;
	logic [DATA_W-1:0] swapped;
	logic [DATA_W-1:0] xor_res;
	logic              bank_wr_en;
	logic [DIR_IDX_W-1:0] bank_wr_idx;
	logic [DATA_W-1:0] bank_wr_data;
	logic [DIR_IDX_W-1:0] bank_rd_idx;
	logic              core_hits_dir;
	logic [2:0]        dir_sel;

	////////////////////////////////////////////////////////////////////////////
	// Decode
	assign is_swap    = instr_valid && instr[MAJOR_HI:MAJOR_LO] == OP_SWAP_MAJOR;
	assign is_xorl    = instr_valid && instr[MAJOR_HI:MAJOR_LO] == OP_XORL_MAJOR;
	assign dir_sel    = instr[2:0];
	assign dir_sel_ok = dir_sel >= DIR_SEL_FIRST && dir_sel <= DIR_SEL_LAST;
	// Accepted for legacy code; out-of-range selectors do nothing but flag
	assign is_dirl    = instr_valid && instr[INSTR_W-1:DIRL_HI_LO] == OP_DIRL_HI;
	assign dest_file  = instr[DEST_BIT];

	// Single cycle: no stall path exists for these opcodes
	assign instr_accepted = is_swap || is_xorl || (is_dirl && dir_sel_ok);
	assign illegal_op     = is_dirl && !dir_sel_ok;

	////////////////////////////////////////////////////////////////////////////
	// Datapath
	assign swapped = {file_rd_data[3:0], file_rd_data[7:4]};
	assign xor_res = acc_r ^ instr[DATA_W-1:0];

	assign file_addr    = instr[ADDR_W-1:0];
	assign file_wr_en   = is_swap && dest_file;
	assign file_wr_data = swapped;

	always_comb begin
		acc_nxt = acc_r;
		if (is_swap && !dest_file) begin
			acc_nxt = swapped;
		end else if (is_xorl) begin
			acc_nxt = xor_res;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			acc_r <= ACC_RESET;
		end else begin
			acc_r <= acc_nxt;
		end
	end

	// Swap and direction load leave the flag alone
	always_ff @(posedge clock) begin
		if (reset) begin
			null_r <= 1'b0;
		end else if (is_xorl) begin
			null_r <= (xor_res == '0);
		end
	end

	assign acc              = acc_r;
	assign result_null_flag = null_r;

	////////////////////////////////////////////////////////////////////////////
	// Direction registers: instruction load wins over a same-cycle file write
	assign core_hits_dir = core_file_addr >= DIR_FILE_BASE
		&& core_file_addr < DIR_FILE_BASE + ADDR_W'(DIR_COUNT);

	always_comb begin
		bank_wr_en   = 1'b0;
		bank_wr_idx  = '0;
		bank_wr_data = acc_r;
		if (is_dirl && dir_sel_ok) begin
			bank_wr_en  = 1'b1;
			bank_wr_idx = DIR_IDX_W'(dir_sel - DIR_SEL_FIRST);
		end else if (core_file_wr_en && core_hits_dir) begin
			bank_wr_en   = 1'b1;
			bank_wr_idx  = DIR_IDX_W'(core_file_addr - DIR_FILE_BASE);
			bank_wr_data = core_file_wr_data;
		end
	end

	// Out-of-range addresses must not alias onto a bank entry; index past the end reads zero
	assign bank_rd_idx = core_hits_dir ? DIR_IDX_W'(core_file_addr - DIR_FILE_BASE)
		: DIR_IDX_W'(DIR_COUNT);

	nsxd_dir_bank u_bank (
		.clock    (clock),
		.reset    (reset),
		.wr_en    (bank_wr_en),
		.wr_idx   (bank_wr_idx),
		.wr_data  (bank_wr_data),
		.rd_idx   (bank_rd_idx),
		.rd_data  (dir_rd_data),
		.dir_flat (dir_regs)
	);
endmodule
`default_nettype wire

// ==== verification/nsxd_exec_checker.sv ====
`default_nettype none
module nsxd_exec_checker
	import nsxd_pkg::*;
(
	input wire logic        clock, reset, instr_valid, file_wr_en,
	input wire logic        result_null_flag, instr_accepted, illegal_op,
	input wire logic [13:0] instr,
	input wire logic [7:0]  file_rd_data, file_wr_data, acc,
	input wire logic [23:0] dir_regs
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	wire       sw  = instr_valid && instr[13:8] == 6'h0e;
	wire       xl  = instr_valid && instr[13:8] == 6'h3a;
	wire       dl  = instr_valid && instr[13:3] == 11'h00c;
	wire [7:0] lit = instr[7:0];
	sequence xor_s; xl; endsequence
	swap_data_a:
		assert property (sw |-> file_wr_data == {file_rd_data[3:0], file_rd_data[7:4]})
		else $error("swap data wrong");
	swap_acc_a:
		assert property (sw && !instr[7] |-> !file_wr_en ##1 acc == $past(file_wr_data))
		else $error("swap to acc wrong");
	swap_file_a:
		assert property (sw && instr[7] |-> file_wr_en ##1 $stable(acc) && $stable(result_null_flag))
		else $error("swap to file wrong");
	dir_load_a:
		assert property (dl && instr[2:0] == 3'h6 |=> dir_regs[15:8] == $past(acc))
		else $error("direction load wrong");
	dir_legal_a:
		assert property (dl |-> illegal_op == (instr[2:0] < 3'h5) && instr_accepted == !illegal_op)
		else $error("direction decode wrong");
	xor_acc_a:
		assert property (xor_s |=> acc == ($past(acc) ^ $past(lit)))
		else $error("xor result wrong");
	xor_flag_a:
		assert property (xor_s |=> result_null_flag == (acc == 8'h00))
		else $error("zero flag wrong");
	xor_file_a:
		assert property (xl |-> !file_wr_en && instr_accepted)
		else $error("xor wrote file");
	flag_keep_a:
		assert property (sw || dl |=> $stable(result_null_flag))
		else $error("flag changed by swap or direction load");
	one_cycle_a:
		assert property (sw || xl |-> instr_accepted)
		else $error("instruction not accepted");
endmodule
bind nsxd_exec nsxd_exec_checker chk (.*);
`default_nettype wire

// ==== verification/nsxd_exec_test.sv ====
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
	$display("Error %s expected %h seen %h", n, e, g); end end
module nsxd_exec_test;
	timeunit 1ns;
	timeprecision 1ns;
	import nsxd_pkg::*;
	logic        clock = 0, reset = 1, instr_valid = 0, core_file_wr_en = 0;
	logic [13:0] instr = 0;
	logic [7:0]  file_rd_data = 0, core_file_wr_data = 0, file_wr_data, dir_rd_data, acc, a;
	logic [6:0]  core_file_addr = 0, file_addr;
	logic [23:0] dir_regs;
	logic        file_wr_en, result_null_flag, instr_accepted, illegal_op;
	int          bad_count = 0, comparisons = 0;
	nsxd_exec dut (.*);
	initial forever #20 clock = ~clock;
	// Issued at the falling edge; comb outputs settle before checks
	task put(input logic [13:0] i);
		instr = i;
		instr_valid = 1;
		#2;
	endtask
	task t_xor;
		put(14'h3ab5);
		`CHK("wr_en", 1'b0, file_wr_en)
		`CHK("accepted", 1'b1, instr_accepted)
		@(negedge clock);
		put(14'h3aaf);
		@(negedge clock);
		`CHK("acc", 8'h1a, acc)
		`CHK("zero", 1'b0, result_null_flag)
		put(14'h3a1a);
		@(negedge clock);
		`CHK("acc", 8'h00, acc)
		`CHK("zero", 1'b1, result_null_flag)
	endtask
	task t_swap;
		file_rd_data = 8'ha5;
		put(14'h0e05);
		`CHK("swap", 8'h5a, file_wr_data)
		`CHK("addr", 7'h05, file_addr)
		`CHK("wr_en", 1'b0, file_wr_en)
		`CHK("accepted", 1'b1, instr_accepted)
		@(negedge clock);
		`CHK("acc", 8'h5a, acc)
		put(14'h0e85);
		`CHK("wr_en", 1'b1, file_wr_en)
		@(negedge clock);
		`CHK("acc", 8'h5a, acc)
		`CHK("zero", 1'b1, result_null_flag)
	endtask
	task t_dir;
		a = 8'h5a;
		for (int s = 4; s < 8; s++) begin
			put({6'h3a, 8'(s * 17)});
			a = a ^ 8'(s * 17);
			@(negedge clock);
			put({11'h00c, 3'(s)});
			`CHK("illegal", s < 5, illegal_op)
			@(negedge clock);
			if (s < 5) `CHK("dir", 24'hffffff, dir_regs)
			else `CHK("dir", a, dir_regs[(s - 5) * 8 +: 8])
		end
		// Core file write path must reach the same registers
		instr_valid = 0;
		core_file_wr_en = 1;
		core_file_addr = 7'h05;
		core_file_wr_data = 8'h3c;
		@(negedge clock);
		core_file_wr_en = 0;
		@(negedge clock);
		`CHK("dir", 8'h3c, dir_regs[7:0])
		`CHK("dir_rd", 8'h3c, dir_rd_data)
		// An address outside the bank must read zero, not alias an entry
		core_file_addr = 7'h09;
		@(negedge clock);
		`CHK("dir_rd", 8'h00, dir_rd_data)
	endtask
	task stop_test;
		$display("comparisons %0d errors %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge clock);
		reset = 0;
		t_xor;
		t_swap;
		t_dir;
		stop_test;
	end
endmodule
`default_nettype wire
